// file: src/pwa_pkg.sv
package pwa_pkg;

    // ************************************************************
    // channel counts and widths
    // ************************************************************
    localparam int unsigned PWA_NUM_PWM = 4;
    localparam int unsigned PWA_NUM_CAP = 2;
    localparam int unsigned PWA_DATA_W  = 8;
    localparam int unsigned PWA_IRQ_W   = 3;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] PWA_OFF_DUTY3    = 8'h73;
    localparam logic [7:0] PWA_OFF_DUTY2    = 8'h74;
    localparam logic [7:0] PWA_OFF_DUTY1    = 8'h75;
    localparam logic [7:0] PWA_OFF_DUTY0    = 8'h76;
    localparam logic [7:0] PWA_OFF_GATE_POL = 8'h77;
    localparam logic [7:0] PWA_OFF_TCS      = 8'h78;
    localparam logic [7:0] PWA_OFF_LIVE_CNT = 8'h79;
    localparam logic [7:0] PWA_OFF_RELOAD   = 8'h7A;
    localparam logic [7:0] PWA_OFF_CCS      = 8'h7B;
    localparam logic [7:0] PWA_OFF_CAP1     = 8'h7C;
    localparam logic [7:0] PWA_OFF_CAP2     = 8'h7D;
    localparam logic [7:0] PWA_OFF_IRQ_STAT = 8'h7E;
    localparam logic [7:0] PWA_OFF_IRQ_MASK = 8'h7F;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int unsigned PWA_GATE_LSB    = 4;
    localparam int unsigned PWA_POL_LSB     = 0;
    localparam int unsigned PWA_TCS_CLK_LSB = 4;
    localparam int unsigned PWA_TCS_RUN     = 3;
    localparam int unsigned PWA_TCS_FORCE   = 2;
    localparam int unsigned PWA_TCS_WRAP_IE = 1;
    localparam int unsigned PWA_TCS_WRAP_F  = 0;
    localparam int unsigned PWA_CCS_SEL_LSB = 4;
    localparam int unsigned PWA_CCS_IE_LSB  = 2;
    localparam int unsigned PWA_CCS_FLG_LSB = 0;
    localparam int unsigned PWA_IRQ_WRAP    = 2;

    // ************************************************************
    // values
    // ************************************************************
    localparam logic [7:0] PWA_RST_BYTE = 8'h00;
    localparam logic [7:0] PWA_CNT_TOP  = 8'hFF;
    localparam logic [7:0] PWA_CNT_STEP = 8'h01;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pwa_bus_req_t;

    typedef struct packed {
        logic [3:0][7:0] duty;
        logic [3:0][7:0] shadow;
        logic [7:0]      gate_pol;
        logic [3:0]      clk_cfg;
        logic            run;
        logic            wrap_ie;
        logic            wrap_flag;
        logic [7:0]      cnt;
        logic [7:0]      reload;
        logic [1:0]      cap_sel;
        logic [1:0]      cap_ie;
        logic [1:0]      cap_flag;
        logic [1:0][7:0] cap_val;
        logic [1:0]      cap_prev;
        logic            armed;
        logic [2:0]      irq_stat;
        logic [2:0]      irq_mask;
        logic [7:0]      rdata;
        logic [3:0]      pwm;
        logic            wake;
    } pwa_state_t;

endpackage

// file: src/pwa_timer_out.sv
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps

// Function
// - each upper gate bit enables one pwm channel onto its pin.
// - polarity zero drives high while count at or below compare, else low.
// - changing a polarity bit inverts that output immediately.
// - per-channel duty value feeds its compare; reload sets shared first edge.
// - top two capture control bits always read zero.
// - edge select picks falling (0) or rising (1) capture trigger.
// - per-channel capture interrupt allow bit gates its interrupt.
// - hardware sets capture flag on every capture of that channel.
// - reading a capture value register clears its flag, nothing else does.
// - capture latches live count into read-only value register; writes ignored.
// - on overflow counter reloads and outputs take start-of-period level.
// - enabled capture edges raise interrupts and wake device from halt.
module pwa_timer_out
    import pwa_pkg::*;
(
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         arst_n,
    // register port
    input  wire pwa_bus_req_t bus_req,
    output logic [7:0]        bus_rdata,
    // pwm pins
    output logic [3:0]        pwm_o,
    output logic [3:0]        pwm_oe,
    // capture pins and power state
    input  wire logic [1:0]   cap_in,
    input  wire logic         halt_i,
    output logic              wake_o,
    // interrupt
    output logic              irq_o
);

    // ************************************************************
    // decode helpers
    // ************************************************************

    // duty registers sit downward from channel 0
    function automatic logic duty_hit(input logic [7:0] a, input int unsigned k);
        duty_hit = (a == (PWA_OFF_DUTY0 - 8'(k)));
    endfunction

    // capture value registers sit upward from channel 0
    function automatic logic cap_hit(input logic [7:0] a, input int unsigned k);
        cap_hit = (a == (PWA_OFF_CAP1 + 8'(k)));
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    pwa_state_t st_r;
    pwa_state_t st_nxt;
    logic       wrap;
    logic       force_ld;
    logic       period_start;
    logic [1:0] cap_ev;
    logic [7:0] rd_mux;

    // ************************************************************
    // next state
    // ************************************************************

    // write beats counting so software can load the live count on the fly
    always_comb begin
        st_nxt       = st_r;
        wrap         = 1'b0;
        force_ld     = 1'b0;
        cap_ev       = 2'b00;
        rd_mux       = PWA_RST_BYTE;
        st_nxt.armed = 1'b1;

        // free counter wraps from top back to reload
        if (st_r.run) begin
            if (st_r.cnt == PWA_CNT_TOP) begin
                st_nxt.cnt = st_r.reload;
                wrap       = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + PWA_CNT_STEP;
            end
        end

        // register writes
        if (bus_req.wr) begin
            for (int k = 0; k < PWA_NUM_PWM; k++) begin
                if (duty_hit(bus_req.addr, k)) begin
                    st_nxt.duty[k] = bus_req.wdata;
                end
            end
            case (bus_req.addr)
                PWA_OFF_GATE_POL: begin
                    st_nxt.gate_pol = bus_req.wdata;
                end
                PWA_OFF_TCS: begin
                    st_nxt.clk_cfg = bus_req.wdata[PWA_TCS_CLK_LSB +: 4];
                    st_nxt.run     = bus_req.wdata[PWA_TCS_RUN];
                    st_nxt.wrap_ie = bus_req.wdata[PWA_TCS_WRAP_IE];
                    if (bus_req.wdata[PWA_TCS_FORCE]) begin
                        st_nxt.cnt = st_r.reload;
                        force_ld   = 1'b1;
                    end
                end
                PWA_OFF_LIVE_CNT: begin
                    st_nxt.cnt = bus_req.wdata;
                end
                PWA_OFF_RELOAD: begin
                    st_nxt.reload = bus_req.wdata;
                end
                PWA_OFF_CCS: begin
                    st_nxt.cap_sel = bus_req.wdata[PWA_CCS_SEL_LSB +: 2];
                    st_nxt.cap_ie  = bus_req.wdata[PWA_CCS_IE_LSB +: 2];
                end
                PWA_OFF_IRQ_MASK: begin
                    st_nxt.irq_mask = bus_req.wdata[PWA_IRQ_W-1:0];
                end
                default: begin
                    // capture value writes fall here and do nothing
                end
            endcase
        end

        // compare shadows only move at period start, so no period is cut short
        period_start = wrap | force_ld;
        if (period_start) begin
            st_nxt.shadow = st_nxt.duty;
        end

        // read side effects clear first, hardware sets below win
        if (bus_req.rd) begin
            if (bus_req.addr == PWA_OFF_TCS) begin
                st_nxt.wrap_flag = 1'b0;
            end
            if (bus_req.addr == PWA_OFF_IRQ_STAT) begin
                st_nxt.irq_stat = '0;
            end
            for (int k = 0; k < PWA_NUM_CAP; k++) begin
                if (cap_hit(bus_req.addr, k)) begin
                    st_nxt.cap_flag[k] = 1'b0;
                end
            end
        end

        // overflow event
        if (wrap) begin
            st_nxt.wrap_flag = 1'b1;
            if (st_r.wrap_ie) begin
                st_nxt.irq_stat[PWA_IRQ_WRAP] = 1'b1;
            end
        end

        // capture edges; armed blocks a false edge from the reset value of prev
        st_nxt.cap_prev = cap_in;
        for (int k = 0; k < PWA_NUM_CAP; k++) begin
            cap_ev[k] = st_r.armed & (st_r.cap_sel[k] ? (cap_in[k] & ~st_r.cap_prev[k])
                                                      : (~cap_in[k] & st_r.cap_prev[k]));
            if (cap_ev[k]) begin
                st_nxt.cap_val[k]  = st_r.cnt;
                st_nxt.cap_flag[k] = 1'b1;
                if (st_r.cap_ie[k]) begin
                    st_nxt.irq_stat[k] = 1'b1;
                end
            end
        end

        // wake holds while halted once an allowed edge was seen
        st_nxt.wake = halt_i & (st_r.wake | (|(cap_ev & st_r.cap_ie)));

        // level from next count so reload and polarity act the same cycle
        for (int k = 0; k < PWA_NUM_PWM; k++) begin
            st_nxt.pwm[k] = (st_nxt.cnt <= st_nxt.shadow[k]) ^ st_nxt.gate_pol[PWA_POL_LSB + k];
        end

        // read mux, unmapped and reserved bits give zero
        for (int k = 0; k < PWA_NUM_PWM; k++) begin
            if (duty_hit(bus_req.addr, k)) begin
                rd_mux = st_r.duty[k];
            end
        end
        for (int k = 0; k < PWA_NUM_CAP; k++) begin
            if (cap_hit(bus_req.addr, k)) begin
                rd_mux = st_r.cap_val[k];
            end
        end
        case (bus_req.addr)
            PWA_OFF_GATE_POL: rd_mux = st_r.gate_pol;
            PWA_OFF_TCS:      rd_mux = {st_r.clk_cfg, st_r.run, 1'b0, st_r.wrap_ie, st_r.wrap_flag};
            PWA_OFF_LIVE_CNT: rd_mux = st_r.cnt;
            PWA_OFF_RELOAD:   rd_mux = st_r.reload;
            PWA_OFF_CCS:      rd_mux = {2'b00, st_r.cap_sel, st_r.cap_ie, st_r.cap_flag};
            PWA_OFF_IRQ_STAT: rd_mux = {5'h00, st_r.irq_stat};
            PWA_OFF_IRQ_MASK: rd_mux = {5'h00, st_r.irq_mask};
            default: begin
            end
        endcase
        st_nxt.rdata = bus_req.rd ? rd_mux : PWA_RST_BYTE;
    end

    // ************************************************************
    // state register
    // ************************************************************

    // whole block resets to zero
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************

    // undriven pins are left to ordinary port function
    assign pwm_oe    = st_r.gate_pol[PWA_GATE_LSB +: PWA_NUM_PWM];
    assign pwm_o     = st_r.pwm;
    assign bus_rdata = st_r.rdata;
    assign wake_o    = st_r.wake;
    assign irq_o     = |(st_r.irq_stat & st_r.irq_mask);

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    property p_gate;
        bus_req.wr && bus_req.addr == PWA_OFF_GATE_POL |=> pwm_oe == $past(bus_req.wdata[7:4]);
    endproperty
    a_gate: assert property (p_gate) else $error("gate bits not on output enables");

    property p_level;
        st_r.armed |-> pwm_o[0] == ((st_r.cnt <= st_r.shadow[0]) ^ st_r.gate_pol[0]);
    endproperty
    a_level: assert property (p_level) else $error("pwm level wrong for count");

    property p_pol_flip;
        bus_req.wr && bus_req.addr == PWA_OFF_GATE_POL && !st_r.run && st_r.armed
        |=> pwm_o == ($past(st_r.pwm) ^ $past(bus_req.wdata[3:0] ^ st_r.gate_pol[3:0]));
    endproperty
    a_pol_flip: assert property (p_pol_flip) else $error("polarity change not immediate");

    property p_shadow_load;
        period_start |=> st_r.shadow == st_r.duty;
    endproperty
    a_shadow_load: assert property (p_shadow_load) else $error("compare not loaded at period start");

    property p_shadow_hold;
        !period_start |=> $stable(st_r.shadow);
    endproperty
    a_shadow_hold: assert property (p_shadow_hold) else $error("compare moved mid period");

    property p_reserved;
        bus_req.rd && bus_req.addr == PWA_OFF_CCS |=> bus_rdata[7:6] == 2'b00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved capture bits not zero");

    property p_rise_cap;
        st_r.armed && st_r.cap_sel[0] && cap_in[0] && !st_r.cap_prev[0] |-> cap_ev[0];
    endproperty
    a_rise_cap: assert property (p_rise_cap) else $error("rising edge missed");

    property p_cap_irq;
        cap_ev[1] && st_r.cap_ie[1] |=> st_r.irq_stat[1];
    endproperty
    a_cap_irq: assert property (p_cap_irq) else $error("capture interrupt not raised");

    property p_flag_fall;
        $fell(st_r.cap_flag[0]) |-> $past(bus_req.rd && bus_req.addr == PWA_OFF_CAP1);
    endproperty
    a_flag_fall: assert property (p_flag_fall) else $error("flag cleared without read");

    property p_cap_latch;
        cap_ev[0] |=> st_r.cap_val[0] == $past(st_r.cnt) && st_r.cap_flag[0];
    endproperty
    a_cap_latch: assert property (p_cap_latch) else $error("capture did not latch count");

    property p_cap_ro;
        bus_req.wr && bus_req.addr == PWA_OFF_CAP2 && !cap_ev[1] |=> $stable(st_r.cap_val[1]);
    endproperty
    a_cap_ro: assert property (p_cap_ro) else $error("capture value took a write");

    property p_wrap;
        st_r.run && st_r.cnt == PWA_CNT_TOP && !bus_req.wr |=> st_r.cnt == $past(st_r.reload) && st_r.wrap_flag;
    endproperty
    a_wrap: assert property (p_wrap) else $error("overflow did not reload");

    property p_wake;
        halt_i && cap_ev[0] && st_r.cap_ie[0] ##1 halt_i |-> wake_o;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake from halt");

    property p_gate_stable;
        !(bus_req.wr && bus_req.addr == PWA_OFF_GATE_POL) |=> $stable(pwm_oe);
    endproperty
    a_gate_stable: assert property (p_gate_stable) else $error("enables moved without write");

    property p_level_top;
        st_r.armed |-> pwm_o[3] == ((st_r.cnt <= st_r.shadow[3]) ^ st_r.gate_pol[3]);
    endproperty
    a_level_top: assert property (p_level_top) else $error("top channel level wrong");

    property p_duty_write;
        bus_req.wr && bus_req.addr == PWA_OFF_DUTY3 |=> st_r.duty[3] == $past(bus_req.wdata);
    endproperty
    a_duty_write: assert property (p_duty_write) else $error("duty write lost");

    property p_fall_cap;
        st_r.armed && !st_r.cap_sel[1] && !cap_in[1] && st_r.cap_prev[1] |-> cap_ev[1];
    endproperty
    a_fall_cap: assert property (p_fall_cap) else $error("falling edge missed");

    property p_wrong_edge;
        st_r.cap_sel[0] && !cap_in[0] |-> !cap_ev[0];
    endproperty
    a_wrong_edge: assert property (p_wrong_edge) else $error("capture on unselected edge");

    property p_cap_irq_block;
        cap_ev[0] && !st_r.cap_ie[0] && !st_r.irq_stat[0] |=> !st_r.irq_stat[0];
    endproperty
    a_cap_irq_block: assert property (p_cap_irq_block) else $error("blocked capture raised irq");

    property p_cap_latch2;
        cap_ev[1] |=> st_r.cap_val[1] == $past(st_r.cnt) && st_r.cap_flag[1];
    endproperty
    a_cap_latch2: assert property (p_cap_latch2) else $error("second capture did not latch");

    property p_flag_fall2;
        $fell(st_r.cap_flag[1]) |-> $past(bus_req.rd && bus_req.addr == PWA_OFF_CAP2);
    endproperty
    a_flag_fall2: assert property (p_flag_fall2) else $error("second flag cleared without read");

    property p_flag_clear;
        bus_req.rd && bus_req.addr == PWA_OFF_CAP1 && !cap_ev[0] |=> !st_r.cap_flag[0];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("read did not clear flag");

    property p_cap_ro1;
        bus_req.wr && bus_req.addr == PWA_OFF_CAP1 && !cap_ev[0] |=> $stable(st_r.cap_val[0]);
    endproperty
    a_cap_ro1: assert property (p_cap_ro1) else $error("first capture value took a write");

    property p_wrap_irq;
        wrap && st_r.wrap_ie |=> st_r.irq_stat[PWA_IRQ_WRAP];
    endproperty
    a_wrap_irq: assert property (p_wrap_irq) else $error("overflow interrupt not raised");

    property p_count;
        st_r.run && st_r.cnt != PWA_CNT_TOP && !bus_req.wr |=> st_r.cnt == $past(st_r.cnt) + PWA_CNT_STEP;
    endproperty
    a_count: assert property (p_count) else $error("counter did not step");

    property p_stopped;
        !st_r.run && !bus_req.wr |=> $stable(st_r.cnt);
    endproperty
    a_stopped: assert property (p_stopped) else $error("stopped counter moved");

    property p_wake_drop;
        !halt_i |=> !wake_o;
    endproperty
    a_wake_drop: assert property (p_wake_drop) else $error("wake held outside halt");

    property p_force_load;
        bus_req.wr && bus_req.addr == PWA_OFF_TCS && bus_req.wdata[PWA_TCS_FORCE]
        |=> st_r.cnt == $past(st_r.reload) && st_r.shadow == st_r.duty;
    endproperty
    a_force_load: assert property (p_force_load) else $error("forced reload incomplete");

    c_wrap: cover property (wrap ##[1:300] wrap);
    c_cap:  cover property (cap_ev[0] ##[1:50] bus_req.rd && bus_req.addr == PWA_OFF_CAP1);
    c_wake: cover property (halt_i ##1 wake_o);
    c_irq:  cover property ($rose(irq_o));
    c_force: cover property (force_ld);

endmodule

// file: verif/pwa_pin_model.sv
`timescale 1ns/100ps

// ************************************************************
// pin loads and capture signal sources
// ************************************************************
module pwa_pin_model
(
    // pwm pins
    input  wire logic [3:0] pwm_o,
    input  wire logic [3:0] pwm_oe,
    output logic [3:0]      pin_lvl,
    // capture sources
    input  wire logic [1:0] src_lvl,
    output logic [1:0]      cap_in
);
    // pull-up load: an undriven pin floats high, so any stray drive low shows
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            pin_lvl[k] = pwm_oe[k] ? pwm_o[k] : 1'b1;
        end
    end

    // source holds its level until the bench moves it
    assign cap_in = src_lvl;
endmodule

// file: verif/pwm_autoreload_outputs_capture_bench.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch %s expected %h seen %h", n, e, g); end end

module pwm_autoreload_outputs_capture_bench import pwa_pkg::*;;
    logic         clk_sys   = 1'b0;
    logic         arst_n    = 1'b0;
    pwa_bus_req_t bus_req   = '0;
    logic [1:0]   src_lvl   = 2'b00;
    logic         halt_i    = 1'b0;
    logic [7:0]   bus_rdata;
    logic [3:0]   pwm_o, pwm_oe, pin_lvl;
    logic [1:0]   cap_in;
    logic         wake_o, irq_o;
    int           error_cnt = 0, samples_checked = 0, seed = 62514;
    bit           pwm_chk   = 1'b0;
    // ************************************************************
    // behavioural model state
    // ************************************************************
    bit [7:0]     m_duty [4], m_shd [4], m_cap [2], rdq [$];
    bit [7:0]     m_gp, m_cnt, m_rld;
    bit [5:0]     m_cc;
    bit [3:0]     m_clk;
    bit [2:0]     m_stat, m_mask;
    bit [1:0]     m_prev;
    bit           m_run, m_wie, m_wf, m_wake;

    always #20 clk_sys = ~clk_sys;

    pwa_timer_out dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .pwm_o(pwm_o), .pwm_oe(pwm_oe), .cap_in(cap_in), .halt_i(halt_i), .wake_o(wake_o), .irq_o(irq_o));
    pwa_pin_model pin_u (.pwm_o(pwm_o), .pwm_oe(pwm_oe), .pin_lvl(pin_lvl), .src_lvl(src_lvl), .cap_in(cap_in));

    function automatic bit [7:0] rd_val(bit [7:0] a);
        case (a)
            8'h73, 8'h74, 8'h75, 8'h76: rd_val = m_duty[2'(8'h76 - a)];
            8'h77: rd_val = m_gp;
            8'h78: rd_val = {m_clk, m_run, 1'b0, m_wie, m_wf};
            8'h79: rd_val = m_cnt;
            8'h7A: rd_val = m_rld;
            8'h7B: rd_val = {2'b00, m_cc};
            8'h7C: rd_val = m_cap[0];
            8'h7D: rd_val = m_cap[1];
            8'h7E: rd_val = {5'h00, m_stat};
            8'h7F: rd_val = {5'h00, m_mask};
            default: rd_val = 8'h00;
        endcase
    endfunction

    function automatic bit [3:0] pwm_exp();
        for (int k = 0; k < 4; k++) pwm_exp[k] = (m_cnt <= m_shd[k]) ^ m_gp[k];
    endfunction

    // model: compare settled outputs first, then advance on the request taken here
    always @(posedge clk_sys or negedge arst_n) begin : model_p
        bit [7:0] a, d, x;
        bit       w, r, wl, frc, wrap;
        bit [1:0] e;
        if (!arst_n) begin
            m_duty = '{default: '0};
            m_shd = '{default: '0};
            m_cap = '{default: '0};
            {m_gp, m_cnt, m_rld, m_cc, m_clk, m_stat, m_mask, m_prev, m_run, m_wie, m_wf, m_wake} = '0;
            rdq.delete();
        end else begin
            {a, d, w, r} = {bus_req.addr, bus_req.wdata, bus_req.wr, bus_req.rd};
            if (rdq.size() > 0) begin
                x = rdq.pop_front();
                `CHK("read data", x, bus_rdata)
            end else `CHK("idle read data", 8'h00, bus_rdata)
            if (pwm_chk) begin
                `CHK("pwm level", pwm_exp(), pwm_o)
                `CHK("pin level", (pwm_exp() & m_gp[7:4]) | ~m_gp[7:4], pin_lvl)
            end
            `CHK("drive enable", m_gp[7:4], pwm_oe)
            `CHK("irq", |(m_stat & m_mask), irq_o)
            `CHK("wake", m_wake, wake_o)
            if (r) rdq.push_back(rd_val(a));
            wl = w && a == 8'h79;
            frc = w && a == 8'h78 && d[2];
            wrap = m_run && m_cnt == 8'hFF; // a live write at top still counts as a wrap
            e = (cap_in ^ m_prev) & ~(cap_in ^ m_cc[5:4]);
            m_prev = cap_in;
            for (int i = 0; i < 2; i++) if (e[i]) m_cap[i] = m_cnt;
            m_wake = halt_i && (m_wake || |(e & m_cc[3:2]));
            m_stat = {wrap & m_wie, e & m_cc[3:2]} | (m_stat & {3{!(r && a == 8'h7E)}});
            m_cc[1:0] = e | (m_cc[1:0] & ~{r && a == 8'h7D, r && a == 8'h7C});
            m_wf = wrap | (m_wf & !(r && a == 8'h78));
            if (w && a >= 8'h73 && a <= 8'h76) m_duty[2'(8'h76 - a)] = d;
            if (wrap || frc) for (int k = 0; k < 4; k++) m_shd[k] = m_duty[k];
            if (wl) m_cnt = d;
            else if (frc || wrap) m_cnt = m_rld;
            else if (m_run) m_cnt = m_cnt + 8'h01;
            if (w) begin
                case (a)
                    8'h77: m_gp = d;
                    8'h78: {m_clk, m_run, m_wie} = {d[7:3], d[1]};
                    8'h7A: m_rld = d;
                    8'h7B: m_cc[5:2] = d[5:2];
                    8'h7F: m_mask = d[2:0];
                    default: ;
                endcase
            end
        end
    end

    // ************************************************************
    // bus master and verdict
    // ************************************************************
    // entered just after an edge; one assignment per step keeps strobes clean
    task automatic bus(bit w, bit r, bit [7:0] a, bit [7:0] d);
        bus_req <= '{addr: a, wdata: d, wr: w, rd: r};
        @(posedge clk_sys);
    endtask

    task automatic tally_and_finish();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // watchdog far beyond the roughly eight hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        tally_and_finish();
    end

    initial begin : main_p
        int k, j;
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        // reset values, unmapped reads, then ignored and reserved writes
        for (j = 0; j < 2; j++) begin
            for (k = 8'h70; k <= 8'h82; k++) bus(0, 1, 8'(k), 8'h00);
            if (j == 0) begin
                bus(1, 0, 8'h7C, 8'($random(seed)));
                bus(1, 0, 8'h7D, 8'($random(seed)));
                bus(1, 0, 8'h72, 8'hFF);
                bus(1, 0, 8'h7B, 8'hFE);
            end
        end
        pwm_chk <= 1'b1;
        // short period so wraps come often; duty near the reload boundary
        bus(1, 0, 8'h7A, 8'hF0);
        bus(1, 0, 8'h78, 8'h0C);
        repeat (12) begin
            for (k = 0; k < 4; k++) bus(1, 0, 8'(8'h73 + k), 8'(8'hEF + ($random(seed) & 17)));
            bus(1, 0, 8'h77, 8'($random(seed)));
            bus(0, 1, 8'h78, 8'h00);
            bus(0, 1, 8'h79, 8'h00);
            repeat (20) bus(0, 0, 8'h00, 8'h00);
        end
        bus(1, 0, 8'h79, 8'hFD);
        bus(1, 0, 8'h78, 8'h0A);
        // every edge sense and allow mix, mask from k & 7 and halt on odd k
        for (k = 0; k < 16; k++) begin
            bus(1, 0, 8'h7F, 8'(k & 7));
            bus(1, 0, 8'h7B, 8'(k << 2));
            halt_i <= k[0];
            repeat (24) begin
                src_lvl <= 2'($random(seed));
                bus(0, 1'($random(seed)), 8'(8'h7B + ($random(seed) & 3)), 8'h00);
            end
        end
        // stopped counter with clock bits stored: polarity writes flip levels at once
        bus(1, 0, 8'h78, 8'hF0);
        repeat (4) begin
            bus(1, 0, 8'h77, 8'($random(seed)));
            bus(0, 1, 8'h78, 8'h00);
        end
        repeat (4) bus(0, 0, 8'h00, 8'h00);
        tally_and_finish();
    end
endmodule
